//--- design/bgd_gate_drive.sv
// Purpose: Gate command gating, cross-conduction blocking and driver-bias
//          undervoltage lockout of a three-phase half-bridge driver.
// Assumes: Gate commands, part-on and bias comparators arrive from pins;
//          status read and message taken come from same-clock logic.
// Notes:   Pin inputs pass three flops; a change counts once the second
//          and third flops agree, which adds up to four cycles of delay.
//
// How it works
// - Part-on low holds all six gate outputs low.
// - Each gate output follows its own command input.
// - Undriven command inputs read low through external pull-downs.
// - Any active fault forces all gate outputs low.
// - Bias undervoltage is judged only while that driver is driving.
// - Bias low past filter time blocks drive and pulls fault pin low.
// - Bias fault sends an unsolicited two-byte message 0x86 0x04.
// - Bias undervoltage status bit clears after its first read.
// - After one bias fault no further detection until next start-up.
// - Fault pin pulls low on faults only, never on warnings.
// - Both commands of one half-bridge high turns both drives off.
`timescale 1ns/1ps
`default_nettype none
module bgd_gate_drive
   import bgd_pkg::*;
#(
   parameter int FILTER_CYCLES = BIAS_FILTER_CYCLES
) (
   input  wire  logic       CLK_SYS,
   input  wire  logic       RESETN,
   input  wire  bgd_gate_t  GATE_CMD,
   input  wire  logic       PART_ON,
   input  wire  bgd_gate_t  BIAS_LOW,
   input  wire  logic       STATUS_READ,
   input  wire  logic       MSG_TAKEN,
   output var   logic       HIGH_DRIVE_PHASE_A,
   output var   logic       HIGH_DRIVE_PHASE_B,
   output var   logic       HIGH_DRIVE_PHASE_C,
   output var   logic       LOW_DRIVE_PHASE_A,
   output var   logic       LOW_DRIVE_PHASE_B,
   output var   logic       LOW_DRIVE_PHASE_C,
   output var   logic       FAULT_FLAG_OUTPUT_O,
   output var   logic       FAULT_FLAG_OUTPUT_OE,
   output var   logic       STATUS_BIAS_UV,
   output var   logic       MSG_VALID,
   output var   bgd_msg_t   MSG_DATA
);

   localparam int SYNC_W = 13;
   localparam int CNT_W  = $clog2(FILTER_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(FILTER_CYCLES);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic [SYNC_W-1:0] sync3_q;
   logic [SYNC_W-1:0] filt_q;
   logic [SYNC_W-1:0] filt_d;
   wire  [SYNC_W-1:0] pins_raw = {PART_ON, BIAS_LOW, GATE_CMD};
   wire  [SYNC_W-1:0] agree    = ~(sync2_q ^ sync3_q);

   assign filt_d = (sync3_q & agree) | (filt_q & ~agree);

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
         filt_q  <= '0;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         filt_q  <= filt_d;
      end
   end

   // An undriven command pin is pulled low outside, so it reads zero.
   wire bgd_gate_t cmd      = filt_q[5:0];
   wire bgd_gate_t bias_low = filt_q[11:6];
   wire            part_on  = filt_q[12];

   // ---------------------------------------------------------------
   // Lockout state
   // ---------------------------------------------------------------
   bgd_state_t state_q;
   bgd_state_t state_d;
   logic       part_on_q;
   logic [5:0] expired;

   wire start_up = part_on & ~part_on_q;
   wire trip     = (state_q == BGD_ARMED) & (|expired);
   wire fault    = (state_q == BGD_TRIPPED);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         BGD_OFF: begin
            if (start_up) begin
               state_d = BGD_ARMED;
            end
         end
         BGD_ARMED: begin
            if (trip) begin
               state_d = BGD_TRIPPED;
            end else if (!part_on) begin
               state_d = BGD_OFF;
            end
         end
         BGD_TRIPPED: begin
            // Only a fresh start-up re-arms detection.
            if (!part_on) begin
               state_d = BGD_OFF;
            end
         end
         default: begin
            state_d = BGD_OFF;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         state_q   <= BGD_OFF;
         part_on_q <= 1'b0;
      end else begin
         state_q   <= state_d;
         part_on_q <= part_on;
      end
   end

   // ---------------------------------------------------------------
   // Gate gating
   // ---------------------------------------------------------------
   wire [2:0] shoot   = cmd.high & cmd.low;
   wire       allow   = part_on & ~fault & ~trip;
   wire bgd_gate_t drv_d;

   assign drv_d.high = cmd.high & ~shoot & {3{allow}};
   assign drv_d.low  = cmd.low  & ~shoot & {3{allow}};

   bgd_gate_t drv_q;

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         drv_q <= '0;
      end else begin
         drv_q <= drv_d;
      end
   end

   assign HIGH_DRIVE_PHASE_A = drv_q.high[0];
   assign HIGH_DRIVE_PHASE_B = drv_q.high[1];
   assign HIGH_DRIVE_PHASE_C = drv_q.high[2];
   assign LOW_DRIVE_PHASE_A  = drv_q.low[0];
   assign LOW_DRIVE_PHASE_B  = drv_q.low[1];
   assign LOW_DRIVE_PHASE_C  = drv_q.low[2];

   // ---------------------------------------------------------------
   // Bias filter counters, one per driver
   // ---------------------------------------------------------------
   // A driver that is off has a discharged gate, so its bias is not
   // meaningful; its counter is held at zero.
   wire [5:0] judged = drv_q & bias_low;

   for (genvar i = 0; i < 6; i++) begin : g_filter
      logic [CNT_W-1:0] cnt_q;
      logic [CNT_W-1:0] cnt_d;
      assign expired[i] = (cnt_q == CNT_LIMIT);
      // Any break in the condition restarts the count.
      assign cnt_d = !judged[i]  ? '0 :
                     expired[i]  ? cnt_q :
                     cnt_q + CNT_W'(1);
      always_ff @(posedge CLK_SYS or negedge RESETN) begin
         if (!RESETN) begin
            cnt_q <= '0;
         end else begin
            cnt_q <= cnt_d;
         end
      end
   end

   // ---------------------------------------------------------------
   // Fault pin, status bit and message
   // ---------------------------------------------------------------
   logic status_q;
   logic msg_q;
   logic fault_oe_q;

   // Set wins over a read in the same cycle.
   wire status_d = trip | (status_q & ~STATUS_READ);
   wire msg_d    = trip | (msg_q & ~MSG_TAKEN);

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         status_q   <= 1'b0;
         msg_q      <= 1'b0;
         fault_oe_q <= 1'b0;
      end else begin
         status_q   <= status_d;
         msg_q      <= msg_d;
         fault_oe_q <= fault | trip;
      end
   end

   // The open-drain pin only ever pulls low.
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         FAULT_FLAG_OUTPUT_O <= 1'b0;
      end else begin
         FAULT_FLAG_OUTPUT_O <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         MSG_DATA <= '0;
      end else begin
         MSG_DATA <= '{id: MSG_STATUS1_ID, bits: MSG_BIAS_UV_BIT};
      end
   end

   assign FAULT_FLAG_OUTPUT_OE = fault_oe_q;
   assign STATUS_BIAS_UV       = status_q;
   assign MSG_VALID            = msg_q;

endmodule // bgd_gate_drive
`default_nettype wire

//--- inc/bgd_pkg.sv
// Purpose: Shared constants and types for the gate-drive gating block.
// Assumes: System clock of 10 MHz.
// Notes:   Timing counts are derived from times in their own units.
`default_nettype none
package bgd_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS       = 100;
   localparam int BIAS_FILTER_TIME_NS = 10000;
   // A least time, so the count rounds up.
   localparam int BIAS_FILTER_CYCLES  =
      (BIAS_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_STAGES         = 3;

   // ---------------------------------------------------------------
   // Host serial link fault message
   // ---------------------------------------------------------------
   localparam logic [7:0] MSG_STATUS1_ID  = 8'h86;
   localparam logic [7:0] MSG_BIAS_UV_BIT = 8'h04;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   // Index 0 is phase A, 1 is phase B, 2 is phase C.
   typedef struct packed {
      logic [2:0] high;
      logic [2:0] low;
   } bgd_gate_t;

   typedef struct packed {
      logic [7:0] id;
      logic [7:0] bits;
   } bgd_msg_t;

   typedef enum logic [1:0] {
      BGD_OFF     = 2'b00,
      BGD_ARMED   = 2'b01,
      BGD_TRIPPED = 2'b11
   } bgd_state_t;

endpackage
`default_nettype wire

//--- verification/bgd_gate_drive_sva.sv
// Purpose: Port assertions for the gate-drive gating block.
// Assumes: Gate path answers within five cycles.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module bgd_gate_drive_sva
   import bgd_pkg::*;
(
   input wire logic      CLK_SYS,
   input wire logic      RESETN,
   input wire bgd_gate_t GATE_CMD,
   input wire logic      PART_ON,
   input wire bgd_gate_t BIAS_LOW,
   input wire logic      STATUS_READ,
   input wire logic      MSG_TAKEN,
   input wire logic      HIGH_DRIVE_PHASE_A,
   input wire logic      HIGH_DRIVE_PHASE_B,
   input wire logic      HIGH_DRIVE_PHASE_C,
   input wire logic      LOW_DRIVE_PHASE_A,
   input wire logic      LOW_DRIVE_PHASE_B,
   input wire logic      LOW_DRIVE_PHASE_C,
   input wire logic      FAULT_FLAG_OUTPUT_O,
   input wire logic      FAULT_FLAG_OUTPUT_OE,
   input wire logic      STATUS_BIAS_UV,
   input wire logic      MSG_VALID,
   input wire bgd_msg_t  MSG_DATA
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);
   wire logic [5:0] drv = {HIGH_DRIVE_PHASE_C, HIGH_DRIVE_PHASE_B,
      HIGH_DRIVE_PHASE_A, LOW_DRIVE_PHASE_C, LOW_DRIVE_PHASE_B,
      LOW_DRIVE_PHASE_A};
   property p_off;
      !PART_ON [*6] |-> drv == 6'h00;
   endproperty
   a_off: assert property (p_off) else $error("drive while off");
   // Six quiet cycles cover the synchroniser and output register.
   property p_follow;
      ($stable(GATE_CMD) && PART_ON && !FAULT_FLAG_OUTPUT_OE) [*6] |->
         drv == {GATE_CMD.high & ~GATE_CMD.low,
                 GATE_CMD.low & ~GATE_CMD.high};
   endproperty
   a_follow: assert property (p_follow) else $error("drive");
   property p_fault;
      FAULT_FLAG_OUTPUT_OE |-> drv == 6'h00;
   endproperty
   a_fault: assert property (p_fault) else $error("drive in fault");
   property p_od;
      !FAULT_FLAG_OUTPUT_O;
   endproperty
   a_od: assert property (p_od) else $error("fault pin driven high");
   property p_msg;
      $rose(MSG_VALID) |-> MSG_DATA == 16'h8604 && STATUS_BIAS_UV &&
         FAULT_FLAG_OUTPUT_OE;
   endproperty
   a_msg: assert property (p_msg) else $error("bad message");
   property p_rc;
      STATUS_BIAS_UV && STATUS_READ |=> !STATUS_BIAS_UV;
   endproperty
   a_rc: assert property (p_rc) else $error("status kept on read");
   property p_filt;
      (BIAS_LOW == 6'h00) [*8] |-> !$rose(FAULT_FLAG_OUTPUT_OE);
   endproperty
   a_filt: assert property (p_filt) else $error("early trip");
   property p_hold;
      FAULT_FLAG_OUTPUT_OE && PART_ON |=> FAULT_FLAG_OUTPUT_OE;
   endproperty
   a_hold: assert property (p_hold) else $error("fault let go");
endmodule // bgd_gate_drive_sva
`default_nettype wire

//--- verification/bgd_host_model.sv
// Purpose: Host model turning a mode or step code into gate commands.
// Assumes: Code 0 off, 1 bootstrap, 2 lock, 3 to 8 steps one to six.
// Notes:   Code 9 is a broken host that commands every drive at once.
`timescale 1ns/1ps
`default_nettype none
module bgd_host_model
   import bgd_pkg::*;
(
   input  wire logic [3:0] step,
   input  wire logic       pwm_on,
   input  wire logic       coast,
   output var  bgd_gate_t  gate
);
   bgd_gate_t base;
   // Only two windings are ever energised by a step.
   always_comb begin
      case (step)
         4'h1: base = '{3'h0, 3'h7};
         4'h2: base = '{3'h5, 3'h2};
         4'h3: base = '{3'h1, 3'h4};
         4'h4: base = '{3'h2, 3'h4};
         4'h5: base = '{3'h2, 3'h1};
         4'h6: base = '{3'h4, 3'h1};
         4'h7: base = '{3'h4, 3'h2};
         4'h8: base = '{3'h1, 3'h2};
         4'h9: base = '{3'h7, 3'h7};
         default: base = '{3'h0, 3'h0};
      endcase
      // Coasting chops only the highs; the lows keep conducting.
      gate.high = pwm_on ? base.high : 3'h0;
      // Fast decay drops the lows too, reversing winding voltage.
      gate.low  = (pwm_on || coast) ? base.low : 3'h0;
   end
endmodule // bgd_host_model
`default_nettype wire

//--- verification/tb_bgd_gate_drive.sv
// Purpose: Self-checking bench for the gate-drive gating block.
// Assumes: Filter count shortened to four cycles.
// Notes:   Expected drives are worked out from the applied commands.
`timescale 1ns/1ps
`default_nettype none
module tb_bgd_gate_drive
   import bgd_pkg::*;
;
   logic       clk_sys = 1'b0;
   logic       resetn = 1'b0;
   logic       part_on = 1'b0;
   logic       rd = 1'b0;
   logic       tk = 1'b0;
   logic [3:0] step = 4'h0;
   logic       pwm_on = 1'b1;
   logic       coast = 1'b1;
   bgd_gate_t  cmd;
   bgd_gate_t  bias = '0;
   logic       od;
   logic       oe;
   logic       uv;
   logic       mv;
   bgd_msg_t   md;
   wire  [5:0] drv;
   int         n_errors = 0;
   int         checks_done = 0;
   // Run step period; the fast loop aims about 9% slower.
   localparam int RUN_PER  = 12;
   localparam int FAST_PER = (RUN_PER * 100 + 90) / 91;
   localparam int RAMP_DEC = 2;
   localparam int RAMP0    = FAST_PER + 5 * RAMP_DEC;
   always #50 clk_sys = ~clk_sys;
   bgd_host_model bgd_host_model_i (.step(step), .pwm_on(pwm_on),
      .coast(coast), .gate(cmd));
   bgd_gate_drive #(.FILTER_CYCLES(4)) bgd_gate_drive_i (.CLK_SYS(clk_sys),
      .RESETN(resetn), .GATE_CMD(cmd), .PART_ON(part_on), .BIAS_LOW(bias),
      .STATUS_READ(rd), .MSG_TAKEN(tk), .HIGH_DRIVE_PHASE_A(drv[3]),
      .HIGH_DRIVE_PHASE_B(drv[4]), .HIGH_DRIVE_PHASE_C(drv[5]),
      .LOW_DRIVE_PHASE_A(drv[0]), .LOW_DRIVE_PHASE_B(drv[1]),
      .LOW_DRIVE_PHASE_C(drv[2]), .FAULT_FLAG_OUTPUT_O(od),
      .FAULT_FLAG_OUTPUT_OE(oe), .STATUS_BIAS_UV(uv), .MSG_VALID(mv),
      .MSG_DATA(md));
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      if (n_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic wn(int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic t_steps;
      logic [5:0] want;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk_sys);
         step <= (i < 10) ? 4'(i) : 4'(18 - i);
         wn(6);
         want = {cmd.high & ~cmd.low, cmd.low & ~cmd.high};
         chk("drives", drv, want);
      end
   endtask
   // A fixed period stands in for the locked commutation loop in run.
   task automatic t_ramp;
      int         per;
      int         off;
      logic [5:0] want;
      for (int k = 0; k < 12; k++) begin
         // Open-loop steps speed up linearly to the fast-loop target.
         per = (k < 6) ? RAMP0 - RAMP_DEC * k : RUN_PER;
         // The fast loop retunes every step, the slow one once a turn.
         off = (k < 6) ? 6 + k % 2 : 6;
         @(posedge clk_sys);
         step   <= 4'(3 + k % 6);
         pwm_on <= 1'b1;
         coast  <= (k >= 6);
         wn(per - off);
         want = {cmd.high & ~cmd.low, cmd.low & ~cmd.high};
         chk("pwm on", drv, want);
         @(posedge clk_sys);
         pwm_on <= 1'b0;
         wn(off);
         want = {cmd.high & ~cmd.low, cmd.low & ~cmd.high};
         chk("pwm off", drv, want);
      end
      @(posedge clk_sys);
      step   <= 4'h3;
      pwm_on <= 1'b1;
   endtask
   task automatic t_fault;
      @(posedge clk_sys);
      part_on <= 1'b0;
      wn(6);
      chk("drives off", drv, 16'h0000);
      @(posedge clk_sys);
      part_on <= 1'b1;
      bias <= '{3'h3, 3'h0};
      @(posedge clk_sys);
      @(posedge clk_sys);
      bias <= '{3'h2, 3'h0};
      wn(12);
      chk("early trip", {oe, drv}, 16'h000C);
      @(posedge clk_sys);
      bias <= '{3'h1, 3'h0};
      repeat (20) if (oe !== 1'b1) wn(1);
      chk("trip", {oe, uv, mv, drv}, 16'h01C0);
      chk("message", md, 16'h8604);
      chk("fault pin data", od, 16'h0000);
      @(posedge clk_sys);
      rd <= 1'b1;
      tk <= 1'b1;
      wn(1);
      chk("read cycle", {uv, mv}, 16'h0003);
      @(posedge clk_sys);
      rd <= 1'b0;
      tk <= 1'b0;
      wn(20);
      chk("after read", {oe, uv, mv}, 16'h0004);
      @(posedge clk_sys);
      part_on <= 1'b0;
      bias <= '0;
      // The pin lets go one cycle after the lockout state clears.
      wn(7);
      chk("fault clear", oe, 16'h0000);
      @(posedge clk_sys);
      part_on <= 1'b1;
      wn(6);
      chk("restart", drv, 16'h000C);
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      part_on <= 1'b1;
      t_steps();
      t_ramp();
      t_fault();
      report_and_stop();
   end
   initial begin
      repeat (2000) @(posedge clk_sys);
      n_errors++;
      report_and_stop();
   end
endmodule // tb_bgd_gate_drive
bind bgd_gate_drive bgd_gate_drive_sva bgd_gate_drive_sva_i (.*);
`default_nettype wire
